// ==== hw/scc_pkg.sv ====
// Constants, register map and types of the slow and main clock source controller.
`default_nettype none
package scc_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] SUPPLY_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] SUPPLY_MODE_OFS      = 8'h04;
  localparam logic [7:0] SUPPLY_STATUS_OFS    = 8'h08;
  localparam logic [7:0] MAIN_OSC_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] MAIN_FREQ_MEAS_OFS   = 8'h10;
  localparam logic [7:0] OSC_TRIM_OFS         = 8'h14;
  localparam logic [7:0] PM_STATUS_OFS        = 8'h18;
  localparam logic [7:0] PM_IRQ_ENABLE_OFS    = 8'h1c;
  localparam logic [7:0] PM_IRQ_DISABLE_OFS   = 8'h20;
  localparam logic [7:0] PM_IRQ_MASK_OFS      = 8'h24;
  // Field positions.
  localparam int SLOW_XTAL_SEL_BIT  = 0;
  localparam int SLOW_BYPASS_BIT    = 0;
  localparam int SLOW_STATUS_BIT    = 0;
  localparam int RC_ENABLE_BIT      = 0;
  localparam int XTAL_ENABLE_BIT    = 1;
  localparam int RC_FREQ_LSB        = 4;
  localparam int STARTUP_LSB        = 8;
  localparam int SOURCE_SEL_BIT     = 24;
  localparam int FREQ_READY_BIT     = 16;
  localparam int MEAS_RESTART_BIT   = 20;
  localparam int TRIM_FIELD_STRIDE  = 8;
  localparam int TRIM_SEL_POS       = 7;
  // Status bits shared by the power manager status and irq registers.
  localparam int ST_XTAL_STABLE     = 0;
  localparam int ST_SLOW_SOURCE     = 1;
  localparam int ST_RC_STABLE       = 2;
  localparam int ST_SWITCH_DONE     = 3;
  localparam int STATUS_W           = 4;
  // Widths.
  localparam int TRIM_W             = 7;
  localparam int STARTUP_W          = 8;
  localparam int FREQ_W             = 16;
  localparam int NUM_FREQ           = 3;
  // Fast RC frequency codes; the fourth code is reserved.
  localparam logic [1:0] RC_FREQ_8MHZ     = 2'h0;
  localparam logic [1:0] RC_FREQ_16MHZ    = 2'h1;
  localparam logic [1:0] RC_FREQ_24MHZ    = 2'h2;
  localparam logic [1:0] RC_FREQ_RESERVED = 2'h3;
  // Timing.
  localparam int CLK_PERIOD_NS      = 8;
  localparam int RC_SETTLE_NS       = 10000;
  localparam int RC_SETTLE_CYC      = (RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W           = 11;
  localparam logic [2:0] XTAL_DIV_LAST   = 3'h7;
  localparam logic [3:0] MEAS_LAST_PERIOD = 4'hf;
  // Slow clock switch sequence.
  typedef enum logic [2:0] {
    SL_RC, SL_PINS, SL_XTAL_EN, SL_SWITCH, SL_DONE
  } scc_slow_state_t;
endpackage : scc_pkg
`default_nettype wire

// ==== hw/scc_clock_control.sv ====
// Slow and main clock source controller with its AHB-Lite register slave.
// Operation
// - At power-up only the slow RC oscillator runs and is the slow source.
// - Crystal select hands over pins, enables crystal, then disables the RC.
// - Slow source changes only while both sources are low, avoiding runt pulses.
// - Slow source status follows the real source, set when switching ends.
// - After crystal is selected, return to RC is ignored until power-up.
// - Slow crystal pins reset to input mode with pull-up.
// - After reset the fast RC runs at 8 MHz and sources the main clock.
// - Clearing fast RC enable stops it and clears its stable flag.
// - Changing fast RC frequency clears stable, stops an RC-sourced main clock until settled.
// - Fast RC stable flag is a maskable interrupt source.
// - Factory trims are read only; user trims return to defaults on reset.
// - Per frequency select bit picks user trim over factory trim.
// - User trim changes apply immediately while the fast RC runs.
// - Restart bit restarts measurement; ready flag marks a valid count.
// - After reset the main crystal is off and not the main source.
// - Clearing crystal enable stops it and clears its stable flag.
// - Enabling the crystal loads the 8-bit count, decremented every eight slow cycles.
// - Count reaching zero sets crystal stable flag, a maskable interrupt.
// - Main source select switches glitch-free; switch done flag may interrupt.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`default_nettype none
module scc_clock_control (
  input  wire  logic                         clk,
  input  wire  logic                         rst,
  input  wire  logic                         hsel,
  input  wire  logic [31:0]                  haddr,
  input  wire  logic [1:0]                   htrans,
  input  wire  logic                         hwrite,
  input  wire  logic [2:0]                   hsize,
  input  wire  logic [31:0]                  hwdata,
  input  wire  logic                         hready,
  output logic       [31:0]                  hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire  logic                         rcSlowClkIn,
  input  wire  logic                         xtalSlowClkIn,
  input  wire  logic                         mainClockIn,
  input  wire  logic [scc_pkg::TRIM_W-1:0]   factoryTrimLow,
  input  wire  logic [scc_pkg::TRIM_W-1:0]   factoryTrimMid,
  input  wire  logic [scc_pkg::TRIM_W-1:0]   factoryTrimHigh,
  output logic                               slowClockOut,
  output logic                               slowRcEnable,
  output logic                               slowXtalEnable,
  output logic                               slowBypassEnable,
  output logic                               slowPinsToOsc,
  output logic                               slowPinsPullUp,
  output logic                               fastRcEnable,
  output logic       [1:0]                   fastRcFreqSelect,
  output logic       [scc_pkg::TRIM_W-1:0]   fastRcTrim,
  output logic                               mainCrystalEnable,
  output logic                               mainPinsToOsc,
  output logic                               mainSourceActual,
  output logic                               mainClockRun,
  output logic                               irq
);
  import scc_pkg::*;

  // Pin synchronisers: stage one feeds stage two only, stage three is for edges.
  logic [2:0] pinSync1_q;
  logic [2:0] pinSync2_q;
  logic [2:0] pinSync3_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync1_q <= 3'h0;
      pinSync2_q <= 3'h0;
      pinSync3_q <= 3'h0;
    end else begin
      pinSync1_q <= {mainClockIn, xtalSlowClkIn, rcSlowClkIn};
      pinSync2_q <= pinSync1_q;
      pinSync3_q <= pinSync2_q;
    end
  end

  logic rcLvl;
  logic xtLvl;
  logic mainEdge;
  assign rcLvl    = pinSync2_q[0];
  assign xtLvl    = pinSync2_q[1];
  assign mainEdge = pinSync2_q[2] & ~pinSync3_q[2];

  // AHB-Lite address phase capture; the slave never waits and always answers OKAY.
  logic       addrValid;
  logic       wrPend_q;
  logic       wrPend_d;
  logic [7:0] wrAddr_q;
  logic [7:0] wrAddr_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic [31:0] rdMux;
  logic       wr;
  assign addrValid = hsel & htrans[1] & hready;
  assign wr        = wrPend_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_q;

  // Control state.
  scc_slow_state_t       slowState_q, slowState_d;
  logic                  slowOut_q, slowOut_d;
  logic                  bypass_q, bypass_d;
  logic                  rcEn_q, rcEn_d;
  logic [1:0]            rcFreq_q, rcFreq_d;
  logic                  rcStable_q, rcStable_d;
  logic [SETTLE_W-1:0]   settle_q, settle_d;
  logic                  xtEn_q, xtEn_d;
  logic [STARTUP_W-1:0]  xtStartup_q, xtStartup_d;
  logic [STARTUP_W-1:0]  xtCnt_q, xtCnt_d;
  logic [2:0]            xtDiv_q, xtDiv_d;
  logic                  xtCounting_q, xtCounting_d;
  logic                  xtStable_q, xtStable_d;
  logic                  selReq_q, selReq_d;
  logic                  selAct_q, selAct_d;
  logic                  measArmed_q, measArmed_d;
  logic                  measRun_q, measRun_d;
  logic [3:0]            measPer_q, measPer_d;
  logic [FREQ_W-1:0]     freqCount_q, freqCount_d;
  logic                  freqReady_q, freqReady_d;
  logic [TRIM_W-1:0]     userTrim_q [NUM_FREQ];
  logic [TRIM_W-1:0]     userTrim_d [NUM_FREQ];
  logic [NUM_FREQ-1:0]   useUser_q, useUser_d;
  logic [STATUS_W-1:0]   irqMask_q, irqMask_d;

  logic                  slowDone;
  logic                  slowTick;
  logic                  targetStable;
  logic                  switchDone;
  logic [STATUS_W-1:0]   pmStatus;
  logic [1:0]            wrFreq;
  logic                  measRestart;

  // Derived status and pin controls.
  assign slowDone         = (slowState_q == SL_DONE);
  assign slowTick         = slowOut_d & ~slowOut_q;
  assign targetStable     = selReq_q ? xtStable_q : rcStable_q;
  assign switchDone       = (selAct_q == selReq_q) && targetStable;
  assign pmStatus         = {switchDone, rcStable_q, slowDone, xtStable_q};
  assign slowClockOut     = slowOut_q;
  assign slowRcEnable     = ~slowDone;
  assign slowXtalEnable   = (slowState_q != SL_RC) && (slowState_q != SL_PINS);
  assign slowPinsToOsc    = (slowState_q != SL_RC);
  assign slowPinsPullUp   = (slowState_q == SL_RC);
  assign slowBypassEnable = bypass_q;
  assign fastRcEnable     = rcEn_q;
  assign fastRcFreqSelect = rcFreq_q;
  assign mainCrystalEnable = xtEn_q;
  assign mainPinsToOsc    = xtEn_q;
  assign mainSourceActual = selAct_q;
  assign mainClockRun     = selAct_q ? xtStable_q : rcStable_q;
  assign irq              = |(pmStatus & irqMask_q);
  assign wrFreq           = hwdata[RC_FREQ_LSB +: 2];

  // Trim chosen per frequency: factory value unless the user select bit is set.
  logic [TRIM_W-1:0] factoryTrim [NUM_FREQ];
  logic [TRIM_W-1:0] trimPick    [NUM_FREQ];
  assign factoryTrim[0] = factoryTrimLow;
  assign factoryTrim[1] = factoryTrimMid;
  assign factoryTrim[2] = factoryTrimHigh;
  for (genvar i = 0; i < NUM_FREQ; i++) begin : g_trim
    assign trimPick[i] = useUser_q[i] ? userTrim_q[i] : factoryTrim[i];
  end
  // The trim follows the live register, so new user values apply at once.
  assign fastRcTrim = (rcFreq_q == RC_FREQ_24MHZ) ? trimPick[2] :
                      (rcFreq_q == RC_FREQ_16MHZ) ? trimPick[1] : trimPick[0];

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rdMux = 32'h0;
    unique case (haddr[7:0])
      SUPPLY_MODE_OFS:      rdMux[SLOW_BYPASS_BIT] = bypass_q;
      SUPPLY_STATUS_OFS:    rdMux[SLOW_STATUS_BIT] = slowDone;
      MAIN_OSC_CONTROL_OFS: begin
        rdMux[RC_ENABLE_BIT]               = rcEn_q;
        rdMux[XTAL_ENABLE_BIT]             = xtEn_q;
        rdMux[RC_FREQ_LSB +: 2]            = rcFreq_q;
        rdMux[STARTUP_LSB +: STARTUP_W]    = xtStartup_q;
        rdMux[SOURCE_SEL_BIT]              = selReq_q;
      end
      MAIN_FREQ_MEAS_OFS: begin
        rdMux[FREQ_W-1:0]     = freqCount_q;
        rdMux[FREQ_READY_BIT] = freqReady_q;
      end
      OSC_TRIM_OFS: begin
        for (int k = 0; k < NUM_FREQ; k++) begin
          rdMux[k*TRIM_FIELD_STRIDE +: TRIM_W]      = userTrim_q[k];
          rdMux[k*TRIM_FIELD_STRIDE + TRIM_SEL_POS] = useUser_q[k];
        end
      end
      PM_STATUS_OFS:        rdMux[STATUS_W-1:0] = pmStatus;
      PM_IRQ_MASK_OFS:      rdMux[STATUS_W-1:0] = irqMask_q;
      default:              rdMux = 32'h0;
    endcase
  end

  // Bus next state: reads are sampled in the address phase, writes land in the data phase.
  always_comb begin
    wrPend_d = addrValid & hwrite;
    wrAddr_d = addrValid ? haddr[7:0] : wrAddr_q;
    rdData_d = (addrValid && !hwrite) ? rdMux : rdData_q;
  end

  // Main next-state logic for all oscillators, measurement and masks.
  always_comb begin
    slowState_d  = slowState_q;
    slowOut_d    = slowDone ? xtLvl : rcLvl;
    bypass_d     = bypass_q;
    rcEn_d       = rcEn_q;
    rcFreq_d     = rcFreq_q;
    rcStable_d   = rcStable_q;
    settle_d     = settle_q;
    xtEn_d       = xtEn_q;
    xtStartup_d  = xtStartup_q;
    xtCnt_d      = xtCnt_q;
    xtDiv_d      = xtDiv_q;
    xtCounting_d = xtCounting_q;
    xtStable_d   = xtStable_q;
    selReq_d     = selReq_q;
    selAct_d     = selAct_q;
    measArmed_d  = measArmed_q;
    measRun_d    = measRun_q;
    measPer_d    = measPer_q;
    freqCount_d  = freqCount_q;
    freqReady_d  = freqReady_q;
    userTrim_d   = userTrim_q;
    useUser_d    = useUser_q;
    irqMask_d    = irqMask_q;
    measRestart  = 1'b0;

    // Slow switch sequence; once done no write can bring the RC back.
    unique case (slowState_q)
      SL_RC: begin
        if (wr && wrAddr_q == SUPPLY_CONTROL_OFS && hwdata[SLOW_XTAL_SEL_BIT]) begin
          slowState_d = SL_PINS;
        end
      end
      SL_PINS:    slowState_d = SL_XTAL_EN;
      SL_XTAL_EN: slowState_d = SL_SWITCH;
      SL_SWITCH: begin
        // Swapping only while both levels are low cannot shorten a pulse.
        if (!rcLvl && !xtLvl) begin
          slowState_d = SL_DONE;
          slowOut_d   = 1'b0;
        end
      end
      SL_DONE:    slowState_d = SL_DONE;
    endcase
    if (wr && wrAddr_q == SUPPLY_MODE_OFS) begin
      bypass_d = hwdata[SLOW_BYPASS_BIT];
    end

    // Fast RC settling counter.
    if (settle_q != '0) begin
      settle_d = settle_q - 1'b1;
      if (settle_q == SETTLE_W'(1)) begin
        rcStable_d = 1'b1;
      end
    end

    // Crystal start-up count, one step per eight slow cycles.
    if (xtCounting_q && slowTick) begin
      xtDiv_d = xtDiv_q + 1'b1;
      if (xtDiv_q == XTAL_DIV_LAST && xtCnt_q != '0) begin
        xtCnt_d = xtCnt_q - 1'b1;
      end
    end
    if (xtCounting_q && xtCnt_q == '0) begin
      xtStable_d   = 1'b1;
      xtCounting_d = 1'b0;
    end

    // Main source follows the request once the target oscillator is stable.
    if (selAct_q != selReq_q && targetStable) begin
      selAct_d    = selReq_q;
      measRestart = 1'b1;
    end

    // Control register writes override the autonomous updates above.
    if (wr && wrAddr_q == MAIN_OSC_CONTROL_OFS) begin
      rcEn_d      = hwdata[RC_ENABLE_BIT];
      xtEn_d      = hwdata[XTAL_ENABLE_BIT];
      xtStartup_d = hwdata[STARTUP_LSB +: STARTUP_W];
      selReq_d    = hwdata[SOURCE_SEL_BIT];
      if (!hwdata[RC_ENABLE_BIT]) begin
        rcStable_d = 1'b0;
        settle_d   = '0;
      end else if (!rcEn_q) begin
        settle_d   = SETTLE_W'(RC_SETTLE_CYC);
      end else if (wrFreq != RC_FREQ_RESERVED && wrFreq != rcFreq_q) begin
        rcFreq_d   = wrFreq;
        rcStable_d = 1'b0;
        settle_d   = SETTLE_W'(RC_SETTLE_CYC);
      end
      if (!hwdata[XTAL_ENABLE_BIT]) begin
        xtStable_d   = 1'b0;
        xtCounting_d = 1'b0;
      end else if (!xtEn_q) begin
        xtCnt_d      = hwdata[STARTUP_LSB +: STARTUP_W];
        xtDiv_d      = 3'h0;
        xtCounting_d = 1'b1;
        xtStable_d   = 1'b0;
      end
    end

    // Measurement restarts on request, on the source stabilising or switching.
    if (!rcStable_q && rcStable_d && !selAct_q) begin
      measRestart = 1'b1;
    end
    if (!xtStable_q && xtStable_d && selAct_q) begin
      measRestart = 1'b1;
    end
    if (wr && wrAddr_q == MAIN_FREQ_MEAS_OFS && hwdata[MEAS_RESTART_BIT]) begin
      measRestart = 1'b1;
    end
    if (measRun_q) begin
      if (mainEdge && freqCount_q != '1) begin
        freqCount_d = freqCount_q + 1'b1;
      end
      if (slowTick) begin
        measPer_d = measPer_q + 1'b1;
        if (measPer_q == MEAS_LAST_PERIOD) begin
          measRun_d   = 1'b0;
          freqReady_d = 1'b1;
        end
      end
    end else if (measArmed_q && slowTick) begin
      measArmed_d = 1'b0;
      measRun_d   = 1'b1;
      measPer_d   = 4'h0;
      freqCount_d = '0;
    end
    if (measRestart) begin
      measArmed_d = 1'b1;
      measRun_d   = 1'b0;
      freqReady_d = 1'b0;
    end

    // User trims and interrupt mask.
    if (wr && wrAddr_q == OSC_TRIM_OFS) begin
      for (int k = 0; k < NUM_FREQ; k++) begin
        userTrim_d[k] = hwdata[k*TRIM_FIELD_STRIDE +: TRIM_W];
        useUser_d[k]  = hwdata[k*TRIM_FIELD_STRIDE + TRIM_SEL_POS];
      end
    end
    if (wr && wrAddr_q == PM_IRQ_ENABLE_OFS) begin
      irqMask_d = irqMask_q | hwdata[STATUS_W-1:0];
    end
    if (wr && wrAddr_q == PM_IRQ_DISABLE_OFS) begin
      irqMask_d = irqMask_q & ~hwdata[STATUS_W-1:0];
    end
  end

  // Registers; reset stands for the supply power-up and returns every default.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_q     <= 1'b0;
      wrAddr_q     <= 8'h00;
      rdData_q     <= 32'h0;
      slowState_q  <= SL_RC;
      slowOut_q    <= 1'b0;
      bypass_q     <= 1'b0;
      rcEn_q       <= 1'b1;
      rcFreq_q     <= RC_FREQ_8MHZ;
      rcStable_q   <= 1'b1;
      settle_q     <= '0;
      xtEn_q       <= 1'b0;
      xtStartup_q  <= '0;
      xtCnt_q      <= '0;
      xtDiv_q      <= 3'h0;
      xtCounting_q <= 1'b0;
      xtStable_q   <= 1'b0;
      selReq_q     <= 1'b0;
      selAct_q     <= 1'b0;
      measArmed_q  <= 1'b1;
      measRun_q    <= 1'b0;
      measPer_q    <= 4'h0;
      freqCount_q  <= '0;
      freqReady_q  <= 1'b0;
      for (int k = 0; k < NUM_FREQ; k++) begin
        userTrim_q[k] <= '0;
      end
      useUser_q    <= '0;
      irqMask_q    <= '0;
    end else begin
      wrPend_q     <= wrPend_d;
      wrAddr_q     <= wrAddr_d;
      rdData_q     <= rdData_d;
      slowState_q  <= slowState_d;
      slowOut_q    <= slowOut_d;
      bypass_q     <= bypass_d;
      rcEn_q       <= rcEn_d;
      rcFreq_q     <= rcFreq_d;
      rcStable_q   <= rcStable_d;
      settle_q     <= settle_d;
      xtEn_q       <= xtEn_d;
      xtStartup_q  <= xtStartup_d;
      xtCnt_q      <= xtCnt_d;
      xtDiv_q      <= xtDiv_d;
      xtCounting_q <= xtCounting_d;
      xtStable_q   <= xtStable_d;
      selReq_q     <= selReq_d;
      selAct_q     <= selAct_d;
      measArmed_q  <= measArmed_d;
      measRun_q    <= measRun_d;
      measPer_q    <= measPer_d;
      freqCount_q  <= freqCount_d;
      freqReady_q  <= freqReady_d;
      userTrim_q   <= userTrim_d;
      useUser_q    <= useUser_d;
      irqMask_q    <= irqMask_d;
    end
  end

  // Checks on the sequencing above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  slow_default_a: assert property (slowState_q == SL_RC |-> slowRcEnable && !slowXtalEnable)
    else $error("RC-only slow state drives wrong oscillator enables");
  slow_sequence_a: assert property (slowState_q == SL_PINS |=> slowState_q == SL_XTAL_EN ##1
    slowState_q == SL_SWITCH && slowXtalEnable && slowRcEnable)
    else $error("Slow crystal hand-over out of order");
  slow_glitch_a: assert property ($rose(slowDone) |-> !$past(rcLvl) && !$past(xtLvl))
    else $error("Slow source changed while a clock was high");
  slow_sticky_a: assert property (slowDone |=> slowDone && slowPinsToOsc)
    else $error("Slow source left the crystal");
  rc_disable_a: assert property (wr && wrAddr_q == MAIN_OSC_CONTROL_OFS && !hwdata[RC_ENABLE_BIT]
    |=> !rcStable_q && !fastRcEnable)
    else $error("Fast RC stable flag survived disable");
  rc_freq_a: assert property ($changed(rcFreq_q) |-> !rcStable_q ##1 !rcStable_q)
    else $error("Fast RC stable flag kept across frequency change");
  xtal_stable_a: assert property (xtCounting_q && xtCnt_q == '0 && !(wr && wrAddr_q ==
    MAIN_OSC_CONTROL_OFS) |=> xtStable_q)
    else $error("Crystal stable flag not set at count zero");
  irq_mask_a: assert property (irqMask_q[ST_RC_STABLE] && rcStable_q |-> irq)
    else $error("Unmasked fast RC stable did not raise the interrupt");
  meas_ready_a: assert property ($rose(freqReady_q) |-> $past(measPer_q) == MEAS_LAST_PERIOD)
    else $error("Frequency ready before sixteen slow periods");
  switch_done_a: assert property ($changed(selAct_q) |->
    selAct_q == $past(selReq_q) && $past(targetStable))
    else $error("Main source changed before its target was stable");

  slow_switch_c: cover property ($rose(slowDone));
  xtal_start_c:  cover property ($rose(xtStable_q));
  main_switch_c: cover property ($rose(selAct_q));
  meas_done_c:   cover property ($rose(freqReady_q));
endmodule : scc_clock_control
`default_nettype wire

// ==== test/scc_osc_model.sv ====
// Behavioural oscillators on the far side of the clock source controller.
`default_nettype none
module scc_osc_model (
  input  wire logic rcEn,
  input  wire logic xtalEn,
  input  wire logic mainEn,
  output var  logic rcClk,
  output var  logic xtalClk,
  output var  logic mainClk
);
  timeunit 1ns;
  timeprecision 1ps;
  // A disabled oscillator stops low, so a stale level never passes for a clock.
  initial begin
    rcClk = 1'b0;
    forever #80 rcClk = rcEn & ~rcClk;
  end
  // The bypass clock and the crystal look alike from inside the block.
  initial begin
    xtalClk = 1'b0;
    forever #100 xtalClk = xtalEn & ~xtalClk;
  end
  initial begin
    mainClk = 1'b0;
    forever #15 mainClk = mainEn & ~mainClk;
  end
endmodule : scc_osc_model
`default_nettype wire

// ==== test/test_slow_and_main_clock_source_control.sv ====
// Self-checking bench of the slow and main clock source controller.
`default_nettype none
module test_slow_and_main_clock_source_control;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, rcClk, xtalClk, mainClk, slowRcEn, slowXtalEn, pinsOsc, pullUp, rcEn;
  logic xtalEn, irq, bypass, mainPins, mainSrc, mainRun, slowClk;
  logic [1:0] freqSel;
  logic [6:0] trim;
  int miscompares = 0, comparisons = 0, cyc = 0;
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  scc_clock_control uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .rcSlowClkIn(rcClk),
    .xtalSlowClkIn(xtalClk), .mainClockIn(mainClk), .factoryTrimLow(7'h2a),
    .factoryTrimMid(7'h33), .factoryTrimHigh(7'h44), .slowClockOut(slowClk),
    .slowRcEnable(slowRcEn), .slowXtalEnable(slowXtalEn), .slowBypassEnable(bypass),
    .slowPinsToOsc(pinsOsc), .slowPinsPullUp(pullUp), .fastRcEnable(rcEn),
    .fastRcFreqSelect(freqSel), .fastRcTrim(trim), .mainCrystalEnable(xtalEn),
    .mainPinsToOsc(mainPins), .mainSourceActual(mainSrc), .mainClockRun(mainRun), .irq);
  scc_osc_model osc (.rcEn(slowRcEn), .xtalEn(slowXtalEn), .mainEn(rcEn | xtalEn), .rcClk,
    .xtalClk, .mainClk);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Single AHB-Lite word transfer; waits on hready in both phases.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rdv & m);
  endtask : rd
  // Ends off the edge so port samples never race the design's updates.
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task t_reset;
    rd("status", PM_STATUS_OFS, 32'hf, 32'hc);
    chk("main source", 32'h0, 32'(mainSrc));
    chk("rc freq", 32'h0, 32'(freqSel));
    chk("main runs", 32'h1, 32'(mainRun));
    rd("osc ctl", MAIN_OSC_CONTROL_OFS, 32'h33, 32'h1);
    chk("slow pins", 32'h3, 32'({pinsOsc, pullUp, slowRcEn}));
    chk("xtal off", 32'h0, 32'(xtalEn));
    rd("unmapped", 8'h40, 32'hffffffff, 32'h0);
  endtask : t_reset
  task t_trim;
    bus(1'b1, OSC_TRIM_OFS, 32'hd5);
    wt(2);
    chk("user trim", 32'h55, 32'(trim));
    bus(1'b1, OSC_TRIM_OFS, 32'h55);
    wt(2);
    chk("factory trim", 32'h2a, 32'(trim));
  endtask : t_trim
  // Overlap of both low phases may take some slow periods, hence the long wait.
  task t_slow;
    logic [1:0] seen;
    bus(1'b1, SUPPLY_MODE_OFS, 32'h1);
    rd("bypass", SUPPLY_MODE_OFS, 32'h1, 32'h1);
    chk("bypass pin", 32'h1, 32'(bypass));
    bus(1'b1, SUPPLY_CONTROL_OFS, 32'h1);
    wt(200);
    rd("slow status", SUPPLY_STATUS_OFS, 32'h1, 32'h1);
    rd("pm slow", PM_STATUS_OFS, 32'h2, 32'h2);
    chk("slow enables", 32'h3, 32'({slowRcEn, slowXtalEn, pinsOsc}));
    // The crystal period is 25 cycles, so 30 samples must see both levels.
    seen = 2'h0;
    repeat (30) begin
      wt(1);
      seen = seen | {slowClk, ~slowClk};
    end
    chk("slow clock runs", 32'h3, 32'(seen));
    bus(1'b1, SUPPLY_CONTROL_OFS, 32'h0);
    wt(100);
    rd("no return", SUPPLY_STATUS_OFS, 32'h1, 32'h1);
  endtask : t_slow
  task t_rcfreq;
    bus(1'b1, PM_IRQ_ENABLE_OFS, 32'h4);
    bus(1'b1, MAIN_OSC_CONTROL_OFS, 32'h11);
    rd("rc unstable", PM_STATUS_OFS, 32'h4, 32'h0);
    chk("irq idle", 32'h0, 32'(irq));
    chk("rc freq 16", 32'h1, 32'(freqSel));
    chk("main stopped", 32'h0, 32'(mainRun));
    wt(RC_SETTLE_CYC + 20);
    rd("rc settled", PM_STATUS_OFS, 32'h4, 32'h4);
    chk("main restarted", 32'h1, 32'(mainRun));
    chk("irq raised", 32'h1, 32'(irq));
    bus(1'b1, PM_IRQ_DISABLE_OFS, 32'h4);
    wt(2);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, MAIN_OSC_CONTROL_OFS, 32'h10);
    rd("rc off", PM_STATUS_OFS, 32'h4, 32'h0);
  endtask : t_rcfreq
  task t_xtal;
    bus(1'b1, MAIN_OSC_CONTROL_OFS, 32'h213);
    rd("xtal starting", PM_STATUS_OFS, 32'h1, 32'h0);
    chk("xtal pins", 32'h1, 32'(xtalEn));
    chk("xtal pin mode", 32'h1, 32'(mainPins));
    wt(300);
    rd("xtal counting", PM_STATUS_OFS, 32'h1, 32'h0);
    wt(400);
    rd("xtal stable", PM_STATUS_OFS, 32'h1, 32'h1);
    bus(1'b1, MAIN_OSC_CONTROL_OFS, 32'h1000213);
    rd("switch done", PM_STATUS_OFS, 32'h8, 32'h8);
    chk("main on xtal", 32'h1, 32'(mainSrc));
    chk("xtal runs main", 32'h1, 32'(mainRun));
    bus(1'b1, MAIN_FREQ_MEAS_OFS, 32'h100000);
    rd("meas busy", MAIN_FREQ_MEAS_OFS, 32'h10000, 32'h0);
    wt(500);
    rd("meas ready", MAIN_FREQ_MEAS_OFS, 32'h10000, 32'h10000);
    // Sixteen 200 ns slow periods hold 106 or 107 edges of the 30 ns main clock.
    chk("freq count", 32'h1, 32'(rdv[15:0] inside {16'h006a, 16'h006b}));
    bus(1'b1, MAIN_OSC_CONTROL_OFS, 32'h11);
    rd("xtal off", PM_STATUS_OFS, 32'h1, 32'h0);
  endtask : t_xtal
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Hang guard, well above the few thousand cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      final_report;
    end
  end
  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    t_reset;
    t_trim;
    t_slow;
    t_rcfreq;
    t_xtal;
    final_report;
  end
endmodule : test_slow_and_main_clock_source_control
`default_nettype wire
